// ### hdl/dfwb_pkg.sv
package dfwb_pkg;

  // ==========================================================================
  // History geometry
  localparam int NUM_CASES = 8;
  localparam int CASE_ENTRIES = 8;
  localparam int HIST_LAST_INDEX = 64;
  localparam int CODE_W = 16;
  localparam int NUMBER_W = 16;
  localparam int TIME_W = 32;
  localparam int VALUE_W = 32;
  localparam int HIST_W = CODE_W + NUMBER_W + TIME_W + VALUE_W;

  // ==========================================================================
  // Register map, byte addresses
  localparam int ADDR_W = 14;
  localparam logic [13:0] ADDR_STATUS = 14'h0000;
  localparam logic [13:0] ADDR_CASE_COUNT = 14'h0004;
  localparam logic [13:0] ADDR_ACTIVE = 14'h0008;
  localparam logic [13:0] ADDR_ACK = 14'h000C;
  localparam logic [13:0] ADDR_IRQ_STATUS = 14'h0010;
  localparam logic [13:0] ADDR_IRQ_CLEAR = 14'h0014;
  localparam logic [13:0] ADDR_IRQ_ENABLE = 14'h0018;
  localparam logic [13:0] ADDR_WARN_BASE = 14'h0020;
  localparam logic [1:0] REGION_REGS = 2'h0;
  localparam logic [1:0] REGION_HIST = 2'h1;
  localparam logic [1:0] REGION_MIRROR = 2'h2;

  // ==========================================================================
  // Field positions
  localparam int FAULT_BIT = 3;
  localparam int WARN_BIT = 7;
  localparam int ACK_BIT = 0;
  localparam int POWER_ACK_BIT = 4;
  localparam int EV_LOGGED = 0;
  localparam int EV_RESOLVED = 1;
  localparam int EV_DROPPED = 2;
  localparam int EV_WARN_RISE = 3;
  localparam int NUM_EVENTS = 4;

  // ==========================================================================
  // Mirror copies
  localparam int MIRROR_AW = 9;
  localparam logic [6:0] PD_LEN = 7'h11;
  localparam logic [6:0] PKW_LEN = 7'h05;
  localparam logic [6:0] PRM_LEN = 7'h40;

  typedef enum logic [2:0] {
    MIR_RX_PD = 3'b000,
    MIR_TX_PD = 3'b001,
    MIR_RX_PKW = 3'b010,
    MIR_TX_PKW = 3'b011,
    MIR_RX_PRM = 3'b100,
    MIR_RX_CFG = 3'b101
  } dfwb_mirror_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_RD1 = 2'b01,
    S_RD2 = 2'b10,
    S_DONE = 2'b11
  } dfwb_bus_state_t;

endpackage

// ### hdl/dfwb_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

interface dfwb_mem_if #(
  parameter int AW = 6,
  parameter int DW = 16
) ();
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [DW-1:0] wrData;
  logic [AW-1:0] rdAddr;
  logic [DW-1:0] rdData;

  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

`default_nettype wire

// ### hdl/dfwb_mem.sv
`timescale 1ns/1ps
`default_nettype none

// Plain one-write one-read memory; contents are not reset, so the owner
// must mask words it has not written yet.
module dfwb_mem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input wire logic clk_sys,
  dfwb_mem_if.mem port
);
  logic [DW-1:0] store [2**AW];

  always_ff @(posedge clk_sys) begin
    if (port.wrEn) begin
      store[port.wrAddr] <= port.wrData;
    end
  end

  always_ff @(posedge clk_sys) begin
    port.rdData <= store[port.rdAddr];
  end
endmodule

`default_nettype wire

// ### hdl/dfwb_irq.sv
`timescale 1ns/1ps
`default_nettype none

module dfwb_irq #(
  parameter int N = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [N-1:0] setEvents,
  input wire logic clearWrite,
  input wire logic enableWrite,
  input wire logic [N-1:0] writeData,
  output logic [N-1:0] status,
  output logic [N-1:0] enable,
  output logic irq
);
  logic [N-1:0] status_q;
  logic [N-1:0] enable_q;
  logic irq_q;

  // Set is applied after clear so an event in the clearing cycle survives.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~(clearWrite ? writeData : '0)) | setEvents;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enable_q <= '0;
    end else if (enableWrite) begin
      enable_q <= writeData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & enable_q);
    end
  end

  assign status = status_q;
  assign enable = enable_q;
  assign irq = irq_q;
endmodule

`default_nettype wire

// ### hdl/dfwb_recorder.sv
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Function
// - History is eight cases of eight entries.
// - Each entry keeps code, number, time, value.
// - Power-up clears the whole history.
// - New faults fill active case in order.
// - Faults beyond eight in a case dropped.
// - Case resolves when all removed and acknowledged.
// - Resolve shifts every case down by one.
// - Older cases hold acknowledged cases since power-up.
// - Ninth case overwrites and discards the oldest.
// - Count of cases since power-up readable.
// - One power-cycle fault blocks acknowledging all.
// - Status bit three and output show faults.
// - Status bit seven and output show warnings.
// - Warnings readable as bit-coded word group.
// - Process-data copies, seventeen words each, readable.
// - Parameter-channel copies, five words each, readable.
// - Parameterizing and configuration copies, sixty-four words.
module dfwb_recorder #(
  parameter int WARN_WORDS = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic faultEvent,
  input wire logic [15:0] faultCode,
  input wire logic [15:0] faultNumber,
  input wire logic [31:0] faultValue,
  input wire logic faultNeedsPowerCycle,
  input wire logic causeRemovedEvent,
  input wire logic [2:0] causeRemovedIdx,
  input wire logic [WARN_WORDS*16-1:0] warnBits,
  input wire logic mirrorWrite,
  input wire logic [2:0] mirrorSel,
  input wire logic [5:0] mirrorIdx,
  input wire logic [15:0] mirrorData,
  output logic faultPresentFlag,
  output logic warningPresentFlag,
  output logic [15:0] driveStatusWordOne,
  output logic irq
);

  // ==========================================================================
  // Parameter check
  if (WARN_WORDS < 1 || WARN_WORDS > 8) begin : gWarnCheck
    $error("WARN_WORDS must be 1 to 8");
  end

  // ==========================================================================
  // Helpers
  function automatic logic [6:0] mirrorLen(input logic [2:0] sel);
    logic [6:0] len;
    len = 7'h00;
    case (sel)
      dfwb_pkg::MIR_RX_PD, dfwb_pkg::MIR_TX_PD: len = dfwb_pkg::PD_LEN;
      dfwb_pkg::MIR_RX_PKW, dfwb_pkg::MIR_TX_PKW: len = dfwb_pkg::PKW_LEN;
      dfwb_pkg::MIR_RX_PRM, dfwb_pkg::MIR_RX_CFG: len = dfwb_pkg::PRM_LEN;
      default: len = 7'h00;
    endcase
    return len;
  endfunction

  function automatic logic [7:0] lowMask(input logic [3:0] count);
    return 8'((9'h001 << count) - 9'h001);
  endfunction

  // ==========================================================================
  // History state
  dfwb_mem_if #(.AW(6), .DW(dfwb_pkg::HIST_W)) histIf ();
  dfwb_mem_if #(.AW(dfwb_pkg::MIRROR_AW), .DW(16)) mirIf ();

  dfwb_mem #(.AW(6), .DW(dfwb_pkg::HIST_W)) uHistMem (
    .clk_sys(clk_sys),
    .port(histIf.mem)
  );

  dfwb_mem #(.AW(dfwb_pkg::MIRROR_AW), .DW(16)) uMirMem (
    .clk_sys(clk_sys),
    .port(mirIf.mem)
  );

  logic [2:0] caseHead_q;
  logic [3:0] slotCount_q [dfwb_pkg::NUM_CASES];
  logic [7:0] causeGone_q;
  logic [7:0] acked_q;
  logic powerAckReq_q;
  logic [15:0] caseCount_q;
  logic [dfwb_pkg::TIME_W-1:0] opTime_q;
  logic [WARN_WORDS*16-1:0] warn_q;
  logic warnPrev_q;
  logic [3:0] activeCount;
  logic [7:0] entryMask;
  logic resolved;
  logic logAccept;
  logic ackCmd;
  logic [2:0] targetSlot;
  logic [2:0] targetEntry;

  assign activeCount = slotCount_q[caseHead_q];
  assign entryMask = lowMask(activeCount);
  assign resolved = (activeCount != 4'h0) && ((causeGone_q & acked_q & entryMask) == entryMask);
  assign logAccept = faultEvent && (resolved || activeCount < 4'(dfwb_pkg::CASE_ENTRIES));
  assign targetSlot = resolved ? caseHead_q - 3'h1 : caseHead_q;
  assign targetEntry = resolved ? 3'h0 : activeCount[2:0];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      opTime_q <= '0;
    end else begin
      opTime_q <= opTime_q + 1'b1;
    end
  end

  // Counts gate reads, so zeroing them empties the history in one cycle.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      caseHead_q <= 3'h0;
      for (int i = 0; i < dfwb_pkg::NUM_CASES; i++) begin
        slotCount_q[i] <= 4'h0;
      end
    end else begin
      if (resolved) begin
        caseHead_q <= caseHead_q - 3'h1;
        slotCount_q[targetSlot] <= logAccept ? 4'h1 : 4'h0;
      end else if (logAccept) begin
        slotCount_q[caseHead_q] <= activeCount + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      caseCount_q <= 16'h0000;
    end else if (logAccept && targetEntry == 3'h0) begin
      caseCount_q <= caseCount_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      causeGone_q <= 8'h00;
      acked_q <= 8'h00;
      powerAckReq_q <= 1'b0;
    end else if (resolved) begin
      // A fault landing in the resolve cycle opens the new case and keeps its demand.
      causeGone_q <= 8'h00;
      acked_q <= 8'h00;
      powerAckReq_q <= logAccept && faultNeedsPowerCycle;
    end else begin
      if (causeRemovedEvent && 4'(causeRemovedIdx) < activeCount) begin
        causeGone_q[causeRemovedIdx] <= 1'b1;
      end
      if (ackCmd && !powerAckReq_q) begin
        acked_q <= acked_q | (causeGone_q & entryMask);
      end
      if (logAccept && faultNeedsPowerCycle) begin
        powerAckReq_q <= 1'b1;
      end
    end
  end

  assign histIf.wrEn = logAccept;
  assign histIf.wrAddr = {targetSlot, targetEntry};
  assign histIf.wrData = {faultCode, faultNumber, opTime_q, faultValue};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      warn_q <= '0;
      warnPrev_q <= 1'b0;
    end else begin
      warn_q <= warnBits;
      warnPrev_q <= |warnBits;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      faultPresentFlag <= 1'b0;
      warningPresentFlag <= 1'b0;
      driveStatusWordOne <= 16'h0000;
    end else begin
      faultPresentFlag <= activeCount != 4'h0;
      warningPresentFlag <= |warn_q;
      driveStatusWordOne <= 16'h0000;
      driveStatusWordOne[dfwb_pkg::FAULT_BIT] <= activeCount != 4'h0;
      driveStatusWordOne[dfwb_pkg::WARN_BIT] <= |warn_q;
    end
  end

  // ==========================================================================
  // Mirror copies
  assign mirIf.wrEn = mirrorWrite && 7'(mirrorIdx) < mirrorLen(mirrorSel);
  assign mirIf.wrAddr = {mirrorSel, mirrorIdx};
  assign mirIf.wrData = mirrorData;

  // ==========================================================================
  // Bus slave
  dfwb_pkg::dfwb_bus_state_t state_q;
  logic [13:0] addr_q;
  logic wrPend_q;
  logic [31:0] hrdata_q;
  logic histValid_q;
  logic mirValid_q;
  logic taken;
  logic [6:0] histIndex;
  logic [5:0] histLin;
  logic [2:0] histSlot;
  logic [dfwb_pkg::NUM_EVENTS-1:0] irqStatus;
  logic [dfwb_pkg::NUM_EVENTS-1:0] irqEnable;
  logic [dfwb_pkg::NUM_EVENTS-1:0] events;
  logic regWrite;

  assign taken = hsel && hready && htrans[1] && (state_q == dfwb_pkg::S_IDLE
    || state_q == dfwb_pkg::S_DONE);
  assign hreadyout = (state_q == dfwb_pkg::S_IDLE) || (state_q == dfwb_pkg::S_DONE);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign regWrite = wrPend_q && addr_q[13:12] == dfwb_pkg::REGION_REGS;
  assign ackCmd = regWrite && addr_q == dfwb_pkg::ADDR_ACK && hwdata[dfwb_pkg::ACK_BIT];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= dfwb_pkg::S_IDLE;
      addr_q <= 14'h0000;
      wrPend_q <= 1'b0;
    end else begin
      wrPend_q <= taken && hwrite;
      if (taken) begin
        addr_q <= {haddr[13:2], 2'b00};
      end
      case (state_q)
        dfwb_pkg::S_RD1: state_q <= dfwb_pkg::S_RD2;
        dfwb_pkg::S_RD2: state_q <= dfwb_pkg::S_DONE;
        default: begin
          state_q <= (taken && !hwrite) ? dfwb_pkg::S_RD1 : dfwb_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Index 0 of the history has no meaning; logical cases map onto
  // physical slots counted from the head.
  assign histIndex = addr_q[8:2];
  assign histLin = 6'(histIndex - 7'h01);
  assign histSlot = caseHead_q + histLin[5:3];
  assign histIf.rdAddr = {histSlot, histLin[2:0]};
  assign mirIf.rdAddr = addr_q[10:2];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      histValid_q <= 1'b0;
      mirValid_q <= 1'b0;
    end else if (state_q == dfwb_pkg::S_RD1) begin
      histValid_q <= histIndex != 7'h00 && histIndex <= 7'(dfwb_pkg::HIST_LAST_INDEX)
        && 4'(histLin[2:0]) < slotCount_q[histSlot];
      mirValid_q <= 7'(addr_q[7:2]) < mirrorLen(addr_q[10:8]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (state_q == dfwb_pkg::S_RD2) begin
      hrdata_q <= 32'h0000_0000;
      if (addr_q[13:12] == dfwb_pkg::REGION_HIST) begin
        if (histValid_q) begin
          case (addr_q[10:9])
            2'h0: hrdata_q <= 32'(histIf.rdData[95:80]);
            2'h1: hrdata_q <= 32'(histIf.rdData[79:64]);
            2'h2: hrdata_q <= histIf.rdData[63:32];
            default: hrdata_q <= histIf.rdData[31:0];
          endcase
        end
      end else if (addr_q[13:12] == dfwb_pkg::REGION_MIRROR) begin
        if (mirValid_q) begin
          hrdata_q <= 32'(mirIf.rdData);
        end
      end else if (addr_q == dfwb_pkg::ADDR_STATUS) begin
        hrdata_q <= 32'(driveStatusWordOne);
      end else if (addr_q == dfwb_pkg::ADDR_CASE_COUNT) begin
        hrdata_q <= 32'(caseCount_q);
      end else if (addr_q == dfwb_pkg::ADDR_ACTIVE) begin
        hrdata_q <= 32'(activeCount);
        hrdata_q[dfwb_pkg::POWER_ACK_BIT] <= powerAckReq_q;
      end else if (addr_q == dfwb_pkg::ADDR_IRQ_STATUS) begin
        hrdata_q <= 32'(irqStatus);
      end else if (addr_q == dfwb_pkg::ADDR_IRQ_ENABLE) begin
        hrdata_q <= 32'(irqEnable);
      end else if (addr_q >= dfwb_pkg::ADDR_WARN_BASE
          && addr_q < dfwb_pkg::ADDR_WARN_BASE + 14'(WARN_WORDS * 4)) begin
        hrdata_q <= 32'(warn_q[16 * addr_q[4:2] +: 16]);
      end
    end
  end

  // ==========================================================================
  // Interrupts
  always_comb begin
    events = '0;
    events[dfwb_pkg::EV_LOGGED] = logAccept;
    events[dfwb_pkg::EV_RESOLVED] = resolved;
    events[dfwb_pkg::EV_DROPPED] = faultEvent && !logAccept;
    events[dfwb_pkg::EV_WARN_RISE] = (|warnBits) && !warnPrev_q;
  end

  dfwb_irq #(.N(dfwb_pkg::NUM_EVENTS)) uIrq (
    .clk_sys(clk_sys),
    .srst(srst),
    .setEvents(events),
    .clearWrite(regWrite && addr_q == dfwb_pkg::ADDR_IRQ_CLEAR),
    .enableWrite(regWrite && addr_q == dfwb_pkg::ADDR_IRQ_ENABLE),
    .writeData(hwdata[dfwb_pkg::NUM_EVENTS-1:0]),
    .status(irqStatus),
    .enable(irqEnable),
    .irq(irq)
  );

endmodule

`default_nettype wire

// ### testbench/dfwb_recorder_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Port checks
module dfwb_recorder_assertions #(
  parameter int WARN_WORDS = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic faultEvent,
  input wire logic [WARN_WORDS*16-1:0] warnBits,
  input wire logic faultPresentFlag,
  input wire logic warningPresentFlag,
  input wire logic [15:0] driveStatusWordOne,
  input wire logic irq
);
  logic anyWarn;
  logic req;
  assign anyWarn = |warnBits;
  assign req = hready && htrans[1] && hreadyout;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  a_read_wait: assert property (req && !hwrite |=> !hreadyout [*2] ##1 hreadyout)
    else $error("read wait states wrong");
  a_write_nowait: assert property (req && hwrite |=> hreadyout)
    else $error("write stalled");
  a_fault_bit: assert property (driveStatusWordOne[3] == faultPresentFlag)
    else $error("fault bit differs from flag");
  a_warn_bit: assert property (driveStatusWordOne[7] == warningPresentFlag)
    else $error("warning bit differs from flag");
  a_status_spare: assert property ({driveStatusWordOne[15:8],
      driveStatusWordOne[6:4], driveStatusWordOne[2:0]} == 14'h0)
    else $error("spare status bits set");
  // The warning flag lags the inputs by two register stages.
  a_warn_follow: assert property (!$past(srst) && !$past(srst, 2)
      |-> warningPresentFlag == $past(anyWarn, 2))
    else $error("warning flag does not follow inputs");
  a_fault_logged: assert property (faultEvent |-> ##2 faultPresentFlag)
    else $error("fault not shown");
  a_fault_cause: assert property ($rose(faultPresentFlag) |-> $past(faultEvent, 2))
    else $error("fault flag rose without a fault");
  a_reset_clear: assert property (disable iff (1'b0) srst |=> hreadyout && !irq
      && !faultPresentFlag && !warningPresentFlag && driveStatusWordOne == 16'h0)
    else $error("outputs not cleared by reset");
endmodule

`default_nettype wire

// ### testbench/dfwb_ahb_master.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Diagnostic reader on the far side of the register bus
module dfwb_ahb_master (
  input wire logic clk_sys,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end
  // Single word transfers only, so non-consistent data is never taken as a block.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rdv);
    @(posedge clk_sys);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rdv = hrdata;
    // Released lines show the inverse, so a stale value can never pass.
    haddr <= ~a;
    hwdata <= ~wd;
  endtask
endmodule

`default_nettype wire

// ### testbench/dfwb_recorder_tb.sv
`timescale 1ns/1ps
`default_nettype none

module dfwb_recorder_tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic hsel, hwrite, hrdy, hresp, irq, fFlag, wFlag;
  logic [31:0] haddr, hwdata, hrdata, t1, t2;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic fEv = 1'b0, fPc = 1'b0, rmEv = 1'b0, mEv = 1'b0;
  logic [15:0] fc = 16'h0, md = 16'h0, dsw;
  logic [2:0] ri = 3'h0, ms = 3'h0;
  logic [5:0] mi = 6'h0;
  logic [127:0] warn = '0;
  int errorCnt = 0;
  int cmpCount = 0;
  int lens [6] = '{17, 17, 5, 5, 64, 64};
  always #25 clk_sys = ~clk_sys;
  dfwb_recorder dut (
    .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hrdy), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .faultEvent(fEv), .faultCode(fc),
    .faultNumber(~fc), .faultValue({fc, ~fc}), .faultNeedsPowerCycle(fPc),
    .causeRemovedEvent(rmEv), .causeRemovedIdx(ri), .warnBits(warn),
    .mirrorWrite(mEv), .mirrorSel(ms), .mirrorIdx(mi), .mirrorData(md),
    .faultPresentFlag(fFlag), .warningPresentFlag(wFlag),
    .driveStatusWordOne(dsw), .irq(irq)
  );
  dfwb_ahb_master m (
    .clk_sys(clk_sys), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata)
  );
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors %0d compares %0d", errorCnt, cmpCount);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic rc(input logic [13:0] a, input logic [31:0] e);
    logic [31:0] d;
    m.xfer(1'b0, {18'h0, a}, 32'h0, d);
    chk(d, e);
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic [31:0] x;
    m.xfer(1'b1, {18'h0, a}, d, x);
  endtask
  task automatic flt(input logic [15:0] c, input logic pc);
    @(posedge clk_sys);
    fEv <= 1'b1;
    fc <= c;
    fPc <= pc;
    @(posedge clk_sys);
    fEv <= 1'b0;
  endtask
  task automatic rm(input int i);
    @(posedge clk_sys);
    rmEv <= 1'b1;
    ri <= 3'(i);
    @(posedge clk_sys);
    rmEv <= 1'b0;
  endtask
  task automatic mw(input int s, input int i, input logic [15:0] d);
    @(posedge clk_sys);
    mEv <= 1'b1;
    ms <= 3'(s);
    mi <= 6'(i);
    md <= d;
    @(posedge clk_sys);
    mEv <= 1'b0;
  endtask
  function automatic logic [13:0] ha(input int it, input int ix);
    return {3'b010, 2'(it), 7'(ix), 2'b00};
  endfunction
  function automatic logic [13:0] ma(input int s, input int ix);
    return {3'b100, 3'(s), 6'(ix), 2'b00};
  endfunction
  task automatic rst;
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
  endtask
  task automatic clrchk;
    for (int it = 0; it < 4; it++) begin
      for (int i = 1; i <= 64; i++) begin
        rc(ha(it, i), 32'h0);
      end
    end
    rc(14'h0004, 32'h0);
    rc(14'h0008, 32'h0);
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    rst();
    clrchk();
    rc(14'h0040, 32'h0);
    wr(14'h0018, 32'h1);
    for (int k = 0; k < 9; k++) begin
      flt(16'h0A00 + 16'(k), 1'b0);
    end
    chk({31'h0, irq}, 32'h1);
    rc(14'h0010, 32'h5);
    wr(14'h0014, 32'hF);
    rc(14'h0010, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(14'h0018, 32'h0);
    for (int k = 1; k <= 8; k++) begin
      rc(ha(0, k), {16'h0, 16'h09FF + 16'(k)});
      rc(ha(1, k), {16'h0, ~(16'h09FF + 16'(k))});
      rc(ha(3, k), {16'h09FF + 16'(k), ~(16'h09FF + 16'(k))});
    end
    rc(ha(0, 9), 32'h0);
    rc(14'h0008, 32'h8);
    rc(14'h0004, 32'h1);
    rc(14'h0000, 32'h8);
    m.xfer(1'b0, {18'h0, ha(2, 1)}, 32'h0, t1);
    m.xfer(1'b0, {18'h0, ha(2, 2)}, 32'h0, t2);
    chk(t2 - t1, 32'h2);
    for (int k = 0; k < 7; k++) begin
      rm(k);
    end
    wr(14'h000C, 32'h1);
    rm(7);
    rc(14'h0008, 32'h8);
    wr(14'h000C, 32'h1);
    rc(14'h0008, 32'h0);
    rc(ha(0, 1), 32'h0);
    rc(ha(0, 9), 32'h0A00);
    rc(ha(0, 16), 32'h0A07);
    rc(14'h0010, 32'h2);
    for (int k = 1; k <= 8; k++) begin
      flt(16'h0B00 + 16'(k), 1'b0);
      rm(0);
      wr(14'h000C, 32'h1);
    end
    rc(14'h0004, 32'h9);
    rc(ha(0, 9), 32'h0B08);
    rc(ha(0, 57), 32'h0B02);
    rc(ha(0, 58), 32'h0);
    flt(16'h0C00, 1'b1);
    flt(16'h0C01, 1'b0);
    rm(0);
    rm(1);
    wr(14'h000C, 32'h1);
    rc(14'h0008, 32'h12);
    wr(14'h0014, 32'hF);
    wr(14'h0018, 32'h8);
    @(posedge clk_sys);
    warn[37] <= 1'b1;
    rc(14'h0028, 32'h20);
    wr(14'h0000, 32'h0);
    rc(14'h0000, 32'h88);
    chk({16'h0, dsw}, 32'h88);
    chk({31'h0, hresp}, 32'h0);
    chk({30'h0, wFlag, fFlag}, 32'h3);
    rc(14'h0010, 32'h8);
    chk({31'h0, irq}, 32'h1);
    wr(14'h0018, 32'h0);
    rc(14'h0018, 32'h0);
    chk({31'h0, irq}, 32'h0);
    for (int s = 0; s < 6; s++) begin
      mw(s, 0, 16'h5000 + 16'(s));
      mw(s, lens[s] - 1, 16'hA000 + 16'(s));
      if (lens[s] < 64) begin
        mw(s, lens[s], 16'h1234);
        rc(ma(s, lens[s]), 32'h0);
      end
      rc(ma(s, 0), {16'h0, 16'h5000 + 16'(s)});
      rc(ma(s, lens[s] - 1), {16'h0, 16'hA000 + 16'(s)});
    end
    rst();
    clrchk();
    results();
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    errorCnt++;
    results();
  end
endmodule

bind dfwb_recorder dfwb_recorder_assertions #(.WARN_WORDS(WARN_WORDS)) uChk (
  .clk_sys(clk_sys), .srst(srst), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .faultEvent(faultEvent), .warnBits(warnBits),
  .faultPresentFlag(faultPresentFlag), .warningPresentFlag(warningPresentFlag),
  .driveStatusWordOne(driveStatusWordOne), .irq(irq)
);

`default_nettype wire
